// ==== core/hbs_top.sv ====
/*
  holding brake sequencer: drive enable/disable sequencing around a brake
  output, release and engage delays, output ownership and point selection.
  assumes a classic wishbone master on clk_i and same-clock function inputs.
*/
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module hbs_top
  import hbs_pkg::*;
#(
  parameter int TICK_CYCLES = HBS_TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [HBS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  alarm_active_i,
  input  wire logic                  motion_active_i,
  input  wire logic                  tach_level_i,
  output logic                       motor_current_on_o,
  output logic                       motion_start_o,
  output logic      [HBS_NPOINT-1:0] dout_o,
  output logic      [HBS_NPOINT-1:0] dout_oe_o
);
  localparam int REL = 0;
  localparam int ENG = 1;

  hbs_state_e                state;
  logic                      drive_enable_cmd;
  logic [HBS_DLY_W-1:0]      brake_release_delay;
  logic [HBS_DLY_W-1:0]      brake_engage_delay;
  logic [1:0]                brake_output_mode;
  logic [2:0]                brake_point;
  logic [2:0]                output_owner;
  logic [HBS_NPOINT-1:0]     io_point_direction_config;
  logic [HBS_NPOINT-1:0]     gp_out;
  logic                      move_pending;
  logic                      ms_tick;
  logic                      wr_stb;
  logic                      rd_stb;
  logic [31:0]               wmask;
  logic [31:0]               wval;
  logic                      delays_active;
  logic [1:0]                tmr_load;
  logic [HBS_DLY_W-1:0]      tmr_val [2];
  logic [1:0]                tmr_busy;
  logic                      brake_enabled_state;
  logic                      brake_closed;
  logic [2:0]                new_mode_pt;
  logic [1:0]                new_mode;
  logic                      mode_ok;
  logic                      move_req;
  logic                      drive_idle;
  logic [HBS_NPOINT-1:0]     next_dout;
  logic [31:0]               next_rdata;

  hbs_tmr_if tmr [2] ();

  hbs_ms_tick #(
    .DIV    (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (ms_tick)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_tmr
      assign tmr[g].load     = tmr_load[g];
      assign tmr[g].load_val = tmr_val[g];
      assign tmr[g].tick     = ms_tick;
      assign tmr_busy[g]     = tmr[g].busy;
      hbs_delay_timer u_tmr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .t     (tmr[g])
      );
    end
  endgenerate

  // bus strobes: a read is latched with the ack, a write commits at the edge the
  // master samples that ack, so a write never lands before its answer is seen
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wval   = wb_dat_i & wmask;

  assign delays_active = (brake_output_mode == HBS_MODE_ON_CLOSED) ||
                         (brake_output_mode == HBS_MODE_ON_OPEN);

  // mode write: new mode in bits 1:0, io point in bits 6:4
  assign new_mode    = wb_sel_i[0] ? wb_dat_i[HBS_MODE_LSB +: 2] : brake_output_mode;
  assign new_mode_pt = wb_sel_i[0] ? wb_dat_i[HBS_POINT_LSB +: 3] : brake_point;
  // a point not set as output refuses the whole write, so the brake never drives an input
  always_comb begin
    mode_ok = 1'b0;
    if (new_mode == HBS_MODE_FREE) begin
      mode_ok = 1'b1;
    end else if (new_mode == HBS_MODE_ON_CLOSED || new_mode == HBS_MODE_ON_OPEN) begin
      if (new_mode_pt >= 3'h1 && new_mode_pt <= 3'(HBS_NPOINT)) begin
        mode_ok = io_point_direction_config[2'(new_mode_pt - 3'h1)];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_enable_cmd <= 1'b0;
    end else if (wr_stb && wb_adr_i == HBS_REG_CTRL && wb_sel_i[0]) begin
      drive_enable_cmd <= wb_dat_i[HBS_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brake_release_delay <= HBS_DLY_RST;
      brake_engage_delay  <= HBS_DLY_RST;
    end else if (wr_stb && wb_adr_i == HBS_REG_REL_DLY) begin
      brake_release_delay <= (brake_release_delay & ~wmask[14:0]) | wval[14:0];
    end else if (wr_stb && wb_adr_i == HBS_REG_ENG_DLY) begin
      brake_engage_delay  <= (brake_engage_delay & ~wmask[14:0]) | wval[14:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_point_direction_config <= '0;
      gp_out                    <= '0;
    end else if (wr_stb && wb_adr_i == HBS_REG_IO_DIR && wb_sel_i[0]) begin
      io_point_direction_config <= wb_dat_i[HBS_NPOINT-1:0];
    end else if (wr_stb && wb_adr_i == HBS_REG_GP_OUT && wb_sel_i[0]) begin
      gp_out <= wb_dat_i[HBS_NPOINT-1:0];
    end
  end

  // a mode write moves the owner with it; an owner write drops the brake mode only for alarm or motion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brake_output_mode <= HBS_MODE_RST;
      brake_point       <= HBS_POINT_RST;
      output_owner      <= HBS_OWN_RST;
    end else if (wr_stb && wb_adr_i == HBS_REG_MODE && mode_ok) begin
      brake_output_mode <= new_mode;
      if (new_mode == HBS_MODE_FREE) begin
        if (output_owner == HBS_OWN_BRAKE) begin
          output_owner <= HBS_OWN_GP;
        end
      end else begin
        brake_point  <= new_mode_pt;
        output_owner <= HBS_OWN_BRAKE;
      end
    end else if (wr_stb && wb_adr_i == HBS_REG_ASSIGN && wb_sel_i[0]) begin
      // brake ownership is taken only through the mode register
      if (wb_dat_i[2:0] != HBS_OWN_BRAKE && wb_dat_i[2:0] <= HBS_OWN_TACH) begin
        output_owner <= wb_dat_i[2:0];
        if (output_owner == HBS_OWN_BRAKE &&
            (wb_dat_i[2:0] == HBS_OWN_ALARM || wb_dat_i[2:0] == HBS_OWN_MOTION)) begin
          brake_output_mode <= HBS_MODE_FREE;
        end
      end
    end
  end

  // enable sequencing
  always_comb begin
    tmr_load      = 2'b00;
    tmr_val[REL]  = brake_release_delay;
    tmr_val[ENG]  = brake_engage_delay;
    if (state == HBS_ST_OFF && drive_enable_cmd && delays_active) begin
      tmr_load[REL] = 1'b1;
    end
    if ((state == HBS_ST_RELEASE || state == HBS_ST_ON) && !drive_enable_cmd &&
        delays_active) begin
      tmr_load[ENG] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= HBS_ST_OFF;
    end else begin
      case (state)
        HBS_ST_OFF: begin
          if (drive_enable_cmd) begin
            state <= delays_active ? HBS_ST_RELEASE : HBS_ST_ON;
          end
        end
        HBS_ST_RELEASE: begin
          if (!drive_enable_cmd) begin
            state <= delays_active ? HBS_ST_ENGAGE : HBS_ST_OFF;
          end else if (!tmr_busy[REL] || !delays_active) begin
            state <= HBS_ST_ON;
          end
        end
        HBS_ST_ON: begin
          if (!drive_enable_cmd) begin
            state <= delays_active ? HBS_ST_ENGAGE : HBS_ST_OFF;
          end
        end
        HBS_ST_ENGAGE: begin
          // a re-enable waits until the engage delay has run out
          if (!tmr_busy[ENG] || !delays_active) begin
            state <= HBS_ST_OFF;
          end
        end
        default: begin
          state <= HBS_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motor_current_on_o <= 1'b0;
    end else begin
      motor_current_on_o <= (state == HBS_ST_RELEASE) || (state == HBS_ST_ON) ||
                            (state == HBS_ST_ENGAGE && tmr_busy[ENG] && delays_active) ||
                            (state == HBS_ST_OFF && drive_enable_cmd);
    end
  end

  // a request written together with the enable is held until the drive is on
  assign move_req   = wr_stb && wb_adr_i == HBS_REG_CTRL && wb_sel_i[0] &&
                      wb_dat_i[HBS_CTRL_MOVE_BIT];
  assign drive_idle = !drive_enable_cmd &&
                      (state == HBS_ST_OFF || state == HBS_ST_ENGAGE);

  // motion request: a new request in the same cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      move_pending   <= 1'b0;
      motion_start_o <= 1'b0;
    end else begin
      motion_start_o <= 1'b0;
      if (move_req) begin
        move_pending <= 1'b1;
      end else if (state == HBS_ST_ON && move_pending) begin
        move_pending   <= 1'b0;
        motion_start_o <= 1'b1;
      end else if (drive_idle) begin
        move_pending <= 1'b0;
      end
    end
  end

  // output pins
  assign brake_enabled_state = (state == HBS_ST_RELEASE) || (state == HBS_ST_ON);
  assign brake_closed = (brake_output_mode == HBS_MODE_ON_CLOSED) ? brake_enabled_state
                                                                  : !brake_enabled_state;

  always_comb begin
    next_dout = ~gp_out;
    for (int i = 0; i < HBS_NPOINT; i++) begin
      if (3'(i + 1) == brake_point) begin
        case (output_owner)
          HBS_OWN_BRAKE:  next_dout[i] = !brake_closed;
          HBS_OWN_ALARM:  next_dout[i] = !alarm_active_i;
          HBS_OWN_MOTION: next_dout[i] = !motion_active_i;
          HBS_OWN_TACH:   next_dout[i] = !tach_level_i;
          default:        next_dout[i] = !gp_out[i];
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o    <= '1;
      dout_oe_o <= '0;
    end else begin
      dout_o    <= next_dout;
      // a point turned back to input stops driving on the next clock, whoever owns it
      dout_oe_o <= io_point_direction_config;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0;
    if (wb_adr_i == HBS_REG_CTRL) begin
      next_rdata[HBS_CTRL_EN_BIT]   = drive_enable_cmd;
      next_rdata[HBS_CTRL_MOVE_BIT] = move_pending;
    end else if (wb_adr_i == HBS_REG_REL_DLY) begin
      next_rdata[14:0] = brake_release_delay;
    end else if (wb_adr_i == HBS_REG_ENG_DLY) begin
      next_rdata[14:0] = brake_engage_delay;
    end else if (wb_adr_i == HBS_REG_MODE) begin
      next_rdata[HBS_MODE_LSB +: 2]  = brake_output_mode;
      next_rdata[HBS_POINT_LSB +: 3] = brake_point;
    end else if (wb_adr_i == HBS_REG_ASSIGN) begin
      next_rdata[2:0] = output_owner;
    end else if (wb_adr_i == HBS_REG_IO_DIR) begin
      next_rdata[HBS_NPOINT-1:0] = io_point_direction_config;
    end else if (wb_adr_i == HBS_REG_GP_OUT) begin
      next_rdata[HBS_NPOINT-1:0] = gp_out;
    end else if (wb_adr_i == HBS_REG_STATUS) begin
      next_rdata[0] = brake_enabled_state;
      next_rdata[1] = motor_current_on_o;
      next_rdata[2] = tmr_busy[REL];
      next_rdata[3] = tmr_busy[ENG];
      next_rdata[4] = move_pending;
      next_rdata[5] = brake_closed && (output_owner == HBS_OWN_BRAKE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd_stb) begin
      wb_dat_o <= next_rdata;
    end
  end
endmodule

// ==== include/hbs_pkg.sv ====
/*
  shared constants for the holding brake sequencer: register map, field
  positions, reset values, modes, output owners and the millisecond tick.
  assumes a 32-bit classic wishbone slave port at a 100 MHz clock.
*/
package hbs_pkg;
  localparam int          HBS_ADDR_W        = 8;
  localparam int          HBS_DLY_W         = 15;
  localparam int          HBS_NPOINT        = 4;
  // register byte offsets
  localparam logic [7:0]  HBS_REG_CTRL      = 8'h00;
  localparam logic [7:0]  HBS_REG_REL_DLY   = 8'h04;
  localparam logic [7:0]  HBS_REG_ENG_DLY   = 8'h08;
  localparam logic [7:0]  HBS_REG_MODE      = 8'h0c;
  localparam logic [7:0]  HBS_REG_ASSIGN    = 8'h10;
  localparam logic [7:0]  HBS_REG_IO_DIR    = 8'h14;
  localparam logic [7:0]  HBS_REG_GP_OUT    = 8'h18;
  localparam logic [7:0]  HBS_REG_STATUS    = 8'h1c;
  // field positions
  localparam int          HBS_CTRL_EN_BIT   = 0;
  localparam int          HBS_CTRL_MOVE_BIT = 1;
  localparam int          HBS_MODE_LSB      = 0;
  localparam int          HBS_POINT_LSB     = 4;
  // brake output modes
  localparam logic [1:0]  HBS_MODE_ON_CLOSED = 2'h1;
  localparam logic [1:0]  HBS_MODE_ON_OPEN   = 2'h2;
  localparam logic [1:0]  HBS_MODE_FREE      = 2'h3;
  // output owners
  localparam logic [2:0]  HBS_OWN_GP        = 3'h0;
  localparam logic [2:0]  HBS_OWN_ALARM     = 3'h1;
  localparam logic [2:0]  HBS_OWN_BRAKE     = 3'h2;
  localparam logic [2:0]  HBS_OWN_MOTION    = 3'h3;
  localparam logic [2:0]  HBS_OWN_TACH      = 3'h4;
  // reset values
  localparam logic [1:0]  HBS_MODE_RST      = HBS_MODE_FREE;
  localparam logic [2:0]  HBS_POINT_RST     = 3'h1;
  localparam logic [2:0]  HBS_OWN_RST       = HBS_OWN_GP;
  localparam logic [14:0] HBS_DLY_RST       = 15'h0000;
  // millisecond tick timing
  localparam int          HBS_CLK_PERIOD_NS = 10;
  localparam int          HBS_TICK_NS       = 1000000;
  localparam int          HBS_TICK_CYCLES   = HBS_TICK_NS / HBS_CLK_PERIOD_NS;
  typedef enum {HBS_ST_OFF, HBS_ST_RELEASE, HBS_ST_ON, HBS_ST_ENGAGE} hbs_state_e;
endpackage

// ==== include/hbs_tmr_if.sv ====
/*
  carrier between the sequencer and one millisecond delay timer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface hbs_tmr_if;
  import hbs_pkg::*;
  logic                 load;
  logic [HBS_DLY_W-1:0] load_val;
  logic                 tick;
  logic                 busy;
  modport ctl (output load, output load_val, output tick, input busy);
  modport tmr (input load, input load_val, input tick, output busy);
endinterface

// ==== core/hbs_ms_tick.sv ====
/*
  one-cycle enable pulse every DIV clock cycles.
  assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module hbs_ms_tick
  import hbs_pkg::*;
#(
  parameter int DIV = HBS_TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [31:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt >= 32'(DIV - 1)) begin
      cnt    <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== core/hbs_delay_timer.sv ====
/*
  millisecond down-counter: loaded by the sequencer, decremented on the tick.
  assumes load and tick come from the same clock domain.
*/
`timescale 1ns/10ps
module hbs_delay_timer
  import hbs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  hbs_tmr_if.tmr    t
);
  logic [HBS_DLY_W-1:0] cnt;

  // a load may land between ticks, so the real wait is up to one tick short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (t.load) begin
      cnt <= t.load_val;
    end else if (t.tick && cnt != '0) begin
      cnt <= cnt - 15'h0001;
    end
  end

  assign t.busy = (cnt != '0);
endmodule

// ==== dv/hbs_props.sv ====
/*
  port checker for hbs_top: bus answer, reset levels, move and point timing.
  assumes it is bound to hbs_top, one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
module hbs_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        motor_current_on_o,
  input wire logic        motion_start_o,
  input wire logic [3:0]  dout_o,
  input wire logic [3:0]  dout_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_q1;
  logic wr_q2;
  // direction lands two cycles after the write is answered
  always_ff @(posedge clk_i) begin
    wr_q1 <= wb_ack_o && wb_we_i;
    wr_q2 <= wr_q1;
  end
  a_rst_outputs: assert property (disable iff (1'b0) rst_i |=> !motor_current_on_o
    && !motion_start_o && !wb_ack_o) else $error("outputs active after reset");
  a_rst_points: assert property (disable iff (1'b0) rst_i |=> dout_o == 4'hf
    && dout_oe_o == 4'h0) else $error("points not released in reset");
  a_move_powered: assert property (motion_start_o |-> motor_current_on_o)
    else $error("move started without motor current");
  a_move_pulse: assert property (motion_start_o |=> !motion_start_o)
    else $error("move start longer than one cycle");
  a_no_move_on: assert property ($rose(motor_current_on_o) |-> !motion_start_o)
    else $error("move started with the enable");
  a_dir_on_write: assert property ($changed(dout_oe_o) |-> (wb_ack_o && wb_we_i)
    || wr_q1 || wr_q2) else $error("point direction changed without a write");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read answer");
endmodule

// ==== dv/hbs_relay_model.sv ====
/*
  behavioural brake relay wired to one io point of the sequencer.
  assumes a pull-up on the line, so an undriven point reads open.
*/
`timescale 1ns/10ps
module hbs_relay_model #(
  parameter int POINT = 1
) (
  input  wire logic [3:0] dout_i,
  input  wire logic [3:0] oe_i,
  output logic            coil_on_o
);
  logic line;
  // the pull-up wins whenever the point is not driven
  assign line = oe_i[POINT-1] ? dout_i[POINT-1] : 1'b1;
  // low on the line energizes the coil and releases the brake
  assign coil_on_o = !line;
endmodule

// ==== dv/tb_holding_brake_sequencer.sv ====
/*
  self-checking bench for hbs_top with a relay on io point two.
  assumes a 10-cycle tick so that millisecond delays stay short.
*/
`timescale 1ns/10ps
module tb_holding_brake_sequencer
  import hbs_pkg::*;
;
  localparam int TK = 10;
  logic        clk_i, rst_i, cyc, stb, we, alarm, motion, tach, ack, cur_on, mv, coil;
  logic [7:0]  adr;
  logic [3:0]  sel, dout, oe;
  logic [31:0] wdat, rdat, rd;
  int          errors, compares, m_mode, m_pt, m_dir, m_own, c, d, e;
  hbs_top #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .alarm_active_i(alarm), .motion_active_i(motion),
    .tach_level_i(tach), .motor_current_on_o(cur_on), .motion_start_o(mv),
    .dout_o(dout), .dout_oe_o(oe));
  hbs_relay_model #(.POINT(2)) u_relay (.dout_i(dout), .oe_i(oe), .coil_on_o(coil));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; random function levels ride along on every access
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int k;
    @(posedge clk_i);
    {alarm, motion, tach} <= 3'($urandom);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dt;
    sel <= 4'hf;
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk_i);
    if (k == 20) begin
      errors++;
      give_verdict();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  function automatic logic [31:0] mexp();
    return 32'(m_pt * 16 + m_mode);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    wb(1'b1, a, dt);
    if (a == HBS_REG_MODE && (dt[1:0] == 2'h3 || (dt[1:0] != 2'h0 && dt[6:4] inside {[1:4]}
        && m_dir[dt[6:4]-1]))) begin
      m_mode = dt[1:0];
      m_pt = dt[6:4];
      m_own = (m_mode != 3) ? 2 : (m_own == 2 ? 0 : m_own);
    end
    if (a == HBS_REG_ASSIGN && dt[2:0] inside {0, 1, 3, 4}) begin
      if (m_own == 2 && dt[2:0] inside {1, 3}) m_mode = 3;
      m_own = dt[2:0];
    end
    if (a == HBS_REG_IO_DIR) m_dir = dt[3:0];
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    check(rd, ex);
  endtask
  task automatic wait_on(input bit use_mv, input logic lvl, output int n);
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_i);
      #1;
      if ((use_mv ? mv : cur_on) === lvl) return;
    end
    errors++;
    give_verdict();
  endtask
  initial begin
    {cyc, stb, we, alarm, motion, tach} = '0;
    adr = '0;
    sel = '0;
    wdat = '0;
    {errors, compares, m_dir, m_own} = '0;
    m_mode = 3;
    m_pt = 1;
    void'($urandom(32'h7d97));
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check(32'(dout), 32'hf);
    check(32'(oe), 32'h0);
    rchk(HBS_REG_MODE, mexp());
    rchk(HBS_REG_REL_DLY, 32'h0);
    rchk(8'h20, 32'h0);
    wr(HBS_REG_MODE, 32'h21);
    rchk(HBS_REG_MODE, mexp());
    wr(HBS_REG_IO_DIR, 32'h2);
    wr(HBS_REG_MODE, 32'h20);
    wr(HBS_REG_MODE, 32'h21);
    rchk(HBS_REG_MODE, mexp());
    check(32'(oe), 32'h2);
    wr(HBS_REG_REL_DLY, 32'h7fff);
    rchk(HBS_REG_REL_DLY, 32'h7fff);
    for (int md = 1; md <= 2; md++) begin
      d = 2 + $urandom_range(2);
      e = 2 + $urandom_range(2);
      wr(HBS_REG_MODE, 32'(32 + md));
      wr(HBS_REG_REL_DLY, 32'(d));
      wr(HBS_REG_ENG_DLY, 32'(e));
      rchk(HBS_REG_ENG_DLY, 32'(e));
      wr(HBS_REG_CTRL, 32'h1);
      wr(HBS_REG_CTRL, 32'h3);
      wait_on(1'b1, 1'b1, c);
      check(32'(c >= (d - 1) * TK - 6 && c <= d * TK + 6), 32'h1);
      check(32'(coil), 32'(md == 1));
      wr(HBS_REG_CTRL, 32'h0);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'(coil), 32'(md == 2));
      check(32'(cur_on), 32'h1);
      wait_on(1'b0, 1'b0, c);
      check(32'(c >= (e - 1) * TK - 6 && c <= e * TK + 6), 32'h1);
    end
    wr(HBS_REG_MODE, 32'h23);
    wr(HBS_REG_GP_OUT, 32'h2);
    wr(HBS_REG_CTRL, 32'h3);
    wait_on(1'b1, 1'b1, c);
    check(32'(c < 8), 32'h1);
    check(32'(coil), 32'h1);
    wr(HBS_REG_CTRL, 32'h0);
    wait_on(1'b0, 1'b0, c);
    check(32'(c < 4), 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(HBS_REG_MODE, 32'h21);
      wr(HBS_REG_ASSIGN, k ? 32'h3 : 32'h1);
      rchk(HBS_REG_MODE, mexp());
      rchk(HBS_REG_ASSIGN, 32'(m_own));
      check(32'(coil), 32'(k ? motion : alarm));
    end
    wr(HBS_REG_ASSIGN, 32'h7);
    rchk(HBS_REG_ASSIGN, 32'(m_own));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {m_mode, m_pt, m_own, m_dir} = {32'd3, 32'd1, 32'd0, 32'd0};
    rchk(HBS_REG_MODE, mexp());
    give_verdict();
  end
endmodule
bind hbs_top hbs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .motor_current_on_o(motor_current_on_o), .motion_start_o(motion_start_o),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o));
